// >>> hdl/pll_event_interrupt_logic.sv
`timescale 1ns/1ns
`default_nettype none
`include "pll_event_regs.svh"

module pll_event_interrupt_logic
	import pll_event_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic [7:0] address,
	input  wire logic [7:0] writeData,
	input  wire logic       writeStrobe,
	input  wire logic       readStrobe,
	input  wire logic [7:0] sourceState,
	input  wire logic       pll1InputLost,
	input  wire logic       pll2InputLost,
	input  wire logic       altRefRiseOk,
	input  wire logic       altRefFallOk,
	input  wire logic       mainRefRiseOk,
	input  wire logic       mainRefFallOk,
	output var  logic [7:0] readData,
	output var  logic       statusIrq,
	output var  logic       cpuIrq
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	byte_t eventMask;
	byte_t edgeDirectionSelect;
	byte_t eventFlagLatch;
	byte_t sourceLiveView;
	byte_t sourcePrev;
	byte_t stickyStatus;
	byte_t stickyMask;
	logic  allMode;
	logic  intEnable;
	logic  havePrev;

	function automatic logic isWrite(input logic [7:0] where);
		isWrite = writeStrobe && (address == where);
	endfunction

	function automatic logic isRead(input logic [7:0] where);
		isRead = readStrobe && (address == where);
	endfunction

	// ----------------------------------------
	// Source conditioning
	// ----------------------------------------
	// Lock loss caused by input loss is shown as input loss only
	byte_t sourceNow;
	always_comb begin
		sourceNow = sourceState;
		if (pll1InputLost) begin
			sourceNow[`BIT_PLL1_NOINPUT] = 1'b1; // [RQ11]
			sourceNow[`BIT_PLL1_UNLOCK]  = 1'b0; // [RQ11]
		end
		if (pll2InputLost) begin
			sourceNow[`BIT_PLL2_NOINPUT] = 1'b1; // [RQ11]
			sourceNow[`BIT_PLL2_UNLOCK]  = 1'b0; // [RQ11]
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sourceLiveView <= `RESET_BYTE;
			sourcePrev     <= `RESET_BYTE;
			havePrev       <= 1'b0;
		end else begin
			sourceLiveView <= sourceNow; // [RQ7]
			sourcePrev     <= sourceLiveView; // [RQ12]
			havePrev       <= 1'b1;
		end
	end

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	// First cycle after reset has no valid history, so no edge is claimed
	byte_t rising;
	byte_t falling;
	byte_t edgeHit;
	always_comb begin
		rising  = havePrev ? (sourceLiveView & ~sourcePrev) : `RESET_BYTE; // [RQ12]
		falling = havePrev ? (~sourceLiveView & sourcePrev) : `RESET_BYTE; // [RQ12]
		edgeHit = (rising & edgeDirectionSelect) | (falling & ~edgeDirectionSelect); // [RQ9]
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			eventMask           <= `RESET_BYTE;
			edgeDirectionSelect <= `RESET_BYTE;
			allMode             <= 1'b0;
			intEnable           <= 1'b0;
			stickyMask          <= `RESET_BYTE;
		end else begin
			if (isWrite(`ADDR_MASK)) begin
				eventMask <= writeData;
			end
			if (isWrite(`ADDR_DIRECTION)) begin
				edgeDirectionSelect <= writeData;
			end
			if (isWrite(`ADDR_COMBINE)) begin
				allMode   <= writeData[`BIT_ALL_MODE]; // [RQ5]
				intEnable <= writeData[`BIT_ENABLE]; // [RQ6]
			end
			if (isWrite(`ADDR_STICKY_MASK)) begin
				stickyMask <= writeData;
			end
		end
	end

	// ----------------------------------------
	// Event flags
	// ----------------------------------------
	// A new edge wins over a clear written in the same cycle
	byte_t setNow;
	byte_t clearNow;
	always_comb begin
		setNow   = intEnable ? edgeHit : `RESET_BYTE; // [RQ4]
		clearNow = isWrite(`ADDR_FLAG) ? ~writeData : `RESET_BYTE; // [RQ3]
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			eventFlagLatch <= `RESET_BYTE;
		end else begin
			eventFlagLatch <= (eventFlagLatch & ~clearNow) | setNow; // [RQ1] [RQ2]
		end
	end

	// ----------------------------------------
	// Combined interrupt
	// ----------------------------------------
	// In all-mode with every source masked nothing can assert
	logic anyHit;
	logic allHit;
	always_comb begin
		anyHit = |(eventFlagLatch & ~eventMask); // [RQ10]
		allHit = (&(eventFlagLatch | eventMask)) && (eventMask != 8'hff); // [RQ10]
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			statusIrq <= 1'b0;
		end else begin
			statusIrq <= intEnable && (allMode ? allHit : anyHit); // [RQ5] [RQ6]
		end
	end

	// ----------------------------------------
	// Host interrupt
	// ----------------------------------------
	// Sticky copy of flag events for the host; a read clears it
	byte_t stickyClear;
	always_comb begin
		stickyClear = isRead(`ADDR_STICKY) ? 8'hff : `RESET_BYTE;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			stickyStatus <= `RESET_BYTE;
		end else begin
			stickyStatus <= (stickyStatus & ~stickyClear) | setNow;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cpuIrq <= 1'b0;
		end else begin
			cpuIrq <= |(((stickyStatus & ~stickyClear) | setNow) & stickyMask);
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			readData <= `RESET_BYTE;
		end else if (readStrobe) begin
			case (address)
				`ADDR_MASK:        readData <= eventMask;
				`ADDR_DIRECTION:   readData <= edgeDirectionSelect;
				`ADDR_FLAG:        readData <= eventFlagLatch; // [RQ1]
				`ADDR_COMBINE:     readData <= {6'h00, allMode, intEnable};
				`ADDR_REFVALID:    readData <= {altRefRiseOk, altRefFallOk,
					mainRefRiseOk, mainRefFallOk, 4'h0}; // [RQ8]
				`ADDR_LIVE:        readData <= sourceLiveView; // [RQ7]
				`ADDR_STICKY:      readData <= stickyStatus;
				`ADDR_STICKY_MASK: readData <= stickyMask;
				default:           readData <= `RESET_BYTE;
			endcase
		end else begin
			readData <= `RESET_BYTE;
		end
	end

endmodule

`default_nettype wire

// >>> hdl/pll_event_pkg.sv
package pll_event_pkg;
	typedef logic [7:0] byte_t;
endpackage

// >>> hdl/pll_event_regs.svh
// Operation
// RQ1 - Eight sticky event flags, bit 7 PLL1 unlock down to bit 0 PLL2 return.
// RQ2 - A source edge of the selected direction sets its flag until cleared.
// RQ3 - Writing zero to a flag bit clears it; flags are otherwise read-only.
// RQ4 - Flags update only while interrupt enable is 1. Writes that clear flags still take effect while it is 0.
// RQ5 - Combine bit 1: 0 means any unmasked flag, 1 means all unmasked flags.
// RQ6 - Control bit 0 enables the interrupt; when 0 nothing is signalled. cpuIrq still follows stickyStatus bits set earlier, until they are read.
// RQ7 - Live source states stay readable even while interrupts are disabled.
// RQ8 - Reference validity bits 7 to 4 read-only; bits 3 to 0 reserved.
// RQ9 - Direction bit 1 triggers on rising edge, 0 on falling edge.
// RQ10 - A source whose mask bit is 1 never activates the interrupt.
// RQ11 - Input loss during unlock raises only input-loss, not lock-loss status.
// RQ12 - Edges found by comparing each source with its previous-cycle value.
`ifndef PLL_EVENT_REGS_SVH
`define PLL_EVENT_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_MASK        8'h0e
`define ADDR_DIRECTION   8'h0f
`define ADDR_FLAG        8'h10
`define ADDR_COMBINE     8'h11
`define ADDR_REFVALID    8'h12
`define ADDR_LIVE        8'h13
`define ADDR_STICKY      8'h14
`define ADDR_STICKY_MASK 8'h15

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define BIT_ENABLE       0
`define BIT_ALL_MODE     1
`define BIT_PLL1_UNLOCK  7
`define BIT_PLL1_NOINPUT 6
`define BIT_PLL2_UNLOCK  4
`define BIT_PLL2_NOINPUT 3
`define RESET_BYTE       8'h00

`endif

// >>> verif/pll_event_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pll_event_monitor (
	input wire logic       mclk,
	input wire logic       reset_n,
	input wire logic [7:0] address,
	input wire logic [7:0] writeData,
	input wire logic       writeStrobe,
	input wire logic       readStrobe,
	input wire logic [7:0] readData,
	input wire logic       statusIrq
);
	logic [1:0] ctl;
	logic [7:0] mask;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctl <= 2'h0;
			mask <= 8'h00;
		end else if (writeStrobe && address == 8'h11) begin
			ctl <= writeData[1:0];
		end else if (writeStrobe && address == 8'h0e) begin
			mask <= writeData;
		end
	end
	idle_read_a: assert property (!$past(readStrobe) |-> readData == 8'h00)
		else $error("read data not idle");
	ref_rsvd_a: assert property (readStrobe && address == 8'h12 |=> readData[3:0] == 4'h0)
		else $error("reserved bits set");
	ctl_read_a: assert property (readStrobe && address == 8'h11 |=> readData[1:0] == ctl)
		else $error("control readback");
	mask_read_a: assert property (readStrobe && address == 8'h0e |=> readData == mask)
		else $error("mask readback");
	no_map_a: assert property (readStrobe && address > 8'h15 |=> readData == 8'h00)
		else $error("unmapped read");
	irq_off_a: assert property (!ctl[0] && !$past(ctl[0]) |-> !statusIrq)
		else $error("irq while disabled");
	irq_rise_a: assert property ($rose(statusIrq) |-> $past(ctl[0]))
		else $error("irq rose while disabled");
	all_mask_a: assert property (mask == 8'hff && $past(mask) == 8'hff |-> !statusIrq)
		else $error("irq with all masked");
	cover property ($rose(statusIrq));
	cover property (statusIrq && ctl[1]);
	cover property (readStrobe && address == 8'h10);
endmodule
bind pll_event_interrupt_logic pll_event_monitor pll_event_monitor_inst (.mclk(mclk),
	.reset_n(reset_n), .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
	.readStrobe(readStrobe), .readData(readData), .statusIrq(statusIrq));
`default_nettype wire

// >>> verif/pll_source_model.sv
`timescale 1ns/1ns
`default_nettype none
module pll_source_model (
	input  wire logic       mclk,
	input  wire logic [7:0] level,
	input  wire logic       lose1,
	output var  logic [7:0] sourceState = 8'h00,
	output var  logic       pll1InputLost = 1'b0
);
	// A PLL whose input vanishes also drops lock, so both raw lines rise
	always @(posedge mclk) begin
		pll1InputLost <= lose1;
		sourceState <= level | {lose1, lose1, 6'h00};
	end
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import pll_event_pkg::*;
	logic mclk = 0, reset_n = 0, writeStrobe = 0, readStrobe = 0, lose1 = 0, rdPend = 0;
	byte_t address = 0, writeData = 0, level = 0, sourceState, readData;
	logic [3:0] refs = 0;
	logic pll1InputLost, statusIrq, cpuIrq;
	logic lose2 = 0;
	int miscompares = 0, tests_run = 0;
	logic [31:0] seed = 32'h3f17;
	byte_t q[$];
	pll_source_model pll_source_model_inst (.mclk(mclk), .level(level), .lose1(lose1),
		.sourceState(sourceState), .pll1InputLost(pll1InputLost));
	pll_event_interrupt_logic pll_event_interrupt_logic_inst (.mclk(mclk), .reset_n(reset_n),
		.address(address), .writeData(writeData), .writeStrobe(writeStrobe),
		.readStrobe(readStrobe), .sourceState(sourceState), .pll1InputLost(pll1InputLost),
		.pll2InputLost(lose2), .altRefRiseOk(refs[3]), .altRefFallOk(refs[2]),
		.mainRefRiseOk(refs[1]), .mainRefFallOk(refs[0]), .readData(readData),
		.statusIrq(statusIrq), .cpuIrq(cpuIrq));
	initial forever #25 mclk = ~mclk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic check(input byte_t got, input byte_t exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input byte_t a, input byte_t d);
		@(posedge mclk);
		address <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge mclk);
		writeStrobe <= 1'b0;
	endtask
	task automatic rd(input byte_t a, input byte_t e);
		@(posedge mclk);
		address <= a;
		readStrobe <= 1'b1;
		q.push_back(e);
		@(posedge mclk);
		readStrobe <= 1'b0;
	endtask
	task automatic ev(input byte_t s);
		level <= s;
		repeat (5) @(posedge mclk);
	endtask
	task automatic pins(input byte_t e);
		repeat (2) @(posedge mclk);
		check({6'h00, statusIrq, cpuIrq}, e);
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge mclk) begin
		if (rdPend)
			check(readData, q.pop_front());
		rdPend = readStrobe;
	end
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		report_and_stop;
	end
	initial begin
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		for (int a = 14; a < 19; a++)
			rd(a[7:0], 8'h00);
		rd(8'h20, 8'h00);
		repeat (4) begin
			seed = xs(seed);
			refs <= seed[3:0];
			rd(8'h12, {seed[3:0], 4'h0});
		end
		seed = xs(seed);
		ev(seed[7:0]);
		rd(8'h13, seed[7:0]);
		rd(8'h10, 8'h00);
		ev(8'h00);
		wr(8'h0f, 8'hff);
		wr(8'h11, 8'h01);
		wr(8'h15, 8'hff);
		ev(8'hff);
		rd(8'h10, 8'hff);
		pins(8'h03);
		wr(8'h10, 8'h0f);
		rd(8'h10, 8'h0f);
		rd(8'h14, 8'hff);
		rd(8'h14, 8'h00);
		wr(8'h11, 8'h03);
		pins(8'h00);
		wr(8'h0e, 8'hf0);
		pins(8'h02);
		wr(8'h0e, 8'hff);
		pins(8'h00);
		wr(8'h11, 8'h01);
		rd(8'h11, 8'h01);
		wr(8'h0e, 8'h00);
		wr(8'h0f, 8'h00);
		wr(8'h10, 8'h00);
		ev(8'h00);
		rd(8'h10, 8'hff);
		rd(8'h14, 8'hff);
		wr(8'h11, 8'h00);
		pins(8'h00);
		wr(8'h10, 8'h00);
		ev(8'hff);
		ev(8'h00);
		rd(8'h10, 8'h00);
		wr(8'h0f, 8'hff);
		wr(8'h11, 8'h01);
		ev(8'h00);
		lose1 <= 1'b1;
		ev(8'h00);
		rd(8'h10, 8'h40);
		pins(8'h03);
		rd(8'h14, 8'h40);
		lose2 <= 1'b1;
		ev(8'h10);
		rd(8'h10, 8'h48);
		report_and_stop;
	end
endmodule
`default_nettype wire
